// file: design/htc_heater.sv
// Per-heater control and alarm logic with a strobe register port.
// Assumes measurements are synchronous to CLK and refreshed slowly.
//
// Behaviour
// - On/off: heat below setpoint minus deadband, stop above setpoint plus.
// - On/off or proportional per heater; on/off after reset.
// - Proportional gain is fixed inside; software cannot set it.
// - Power limit caps average current at the configured limit.
// - Limited duty moves in tenths of full duty only.
// - If one tenth duty exceeds the limit, output stays off.
// - Current scaled to full-duty equivalent before low current check.
// - High current alarm suppressed while power limiting.
// - On total sensor loss output takes the configured default.
// - Low temperature alarm clears once temperature exceeds its level.
// - High temperature alarm set whenever temperature exceeds its level.
// - Individual alarm flags for every fault class per heater.
// - Individual flags for the periodic trace test results.
// - Current in 10 mA units, ground fault current in 1 mA units.
// - Temperature in tenths of a degree Celsius.
// - Heater on and alarm summary bits readable in status registers.
// - Every module on a shared link needs a distinct number, same rate.
`timescale 1ns/1ps
module htc_heater
  import htc_pkg::*;
#(
  parameter logic [21:0] TENTH_CYCLES = PWM_TENTH
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic        CE,
  input  wire logic [3:0]  ADDR,
  input  wire logic [15:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  input  wire htc_meas_s   MEAS,
  input  wire htc_ext_s    EXT,
  output logic [15:0]      RDATA,
  output logic             HEAT_OUT,
  output logic             ALARM_ANY
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Current at duty d tenths: i * d / 10, compared as i * d vs lim * 10
  function automatic logic [19:0] htc_times_tenths(input logic [15:0] v,
                                                   input logic [3:0] d);
    htc_times_tenths = v * d;
  endfunction : htc_times_tenths

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [15:0] ctrl_reg, setp_reg, db_reg, lot_reg, hit_reg;
  logic [15:0] loc_reg, hic_reg, pl_reg, gfa_reg, gft_reg;
  logic [AL_COUNT-1:0] alarm_reg;
  logic [3:0]  duty_reg;
  logic        heat_reg, call_reg, lim_reg;
  logic [15:0] full_reg;
  logic [21:0] tick_reg;
  logic [3:0]  phase_reg;
  logic [15:0] rdata_reg;
  logic        heat_out_reg, alarm_any_reg;

  // ----------------------------------------------------------------
  // Decode and combinational control
  // ----------------------------------------------------------------
  wire logic signed [16:0] temp_s = {MEAS.temp[15], MEAS.temp};
  wire logic signed [16:0] sp_s   = {setp_reg[15], setp_reg};
  wire logic signed [16:0] db_s   = {1'b0, db_reg};
  wire logic signed [16:0] on_lvl  = sp_s - db_s;
  wire logic signed [16:0] off_lvl = sp_s + db_s;
  wire logic prop_mode   = ctrl_reg[CTRL_PROP_BIT];
  wire logic enabled     = ctrl_reg[CTRL_ENA_BIT];
  wire logic sensor_lost = !MEAS.sens_a_ok && !MEAS.sens_b_ok;
  wire logic limit_on    = (pl_reg != 16'h0000);

  // On/off decision with hysteresis
  wire logic below_on  = temp_s < on_lvl;
  wire logic above_off = temp_s > off_lvl;
  wire logic call_next = below_on ? 1'b1 : (above_off ? 1'b0 : call_reg);

  // Proportional: band of 4 x deadband below setpoint maps to 0..10 tenths
  wire logic [16:0] band   = {1'b0, db_reg} << PROP_BAND_SHIFT;
  wire logic signed [16:0] err = sp_s - temp_s;
  wire logic [20:0] err_x10 = 21'(err) * 21'(DUTY_FULL);
  wire logic [3:0] prop_duty = (err <= 0) ? 4'h0 :
                               (band == 17'h0 || err_x10 >= 21'(band) * 21'(DUTY_FULL))
                               ? DUTY_FULL : 4'(err_x10 / 21'(band));

  // Full-duty current: measured current scaled back by the duty in use
  wire logic [19:0] cur_x10 = htc_times_tenths(MEAS.current, DUTY_FULL);
  wire logic [15:0] cur_full = (duty_reg == 4'h0) ? MEAS.current :
                               16'(cur_x10 / 20'(duty_reg));

  // Full-duty estimate; while the output is off the last one drawn stands in,
  // otherwise a zero reading would lift the limit and the heater would pulse
  wire logic [15:0] cur_est = (duty_reg == 4'h0) ? full_reg : cur_full;
  wire logic min_step_fits = htc_times_tenths(cur_est, DUTY_ONE)
                             <= htc_times_tenths(pl_reg, DUTY_FULL);

  // Largest tenth whose average current stays within the limit
  logic [3:0] lim_duty;
  always_comb begin
    lim_duty = 4'h0;
    for (int d = 1; d <= int'(DUTY_FULL); d++) begin
      if (htc_times_tenths(cur_est, 4'(d)) <= htc_times_tenths(pl_reg, DUTY_FULL))
        lim_duty = 4'(d);
    end
  end

  // Demand duty before and after limiting
  wire logic [3:0] demand = prop_mode ? prop_duty : (call_next ? DUTY_FULL : 4'h0);
  wire logic       limiting = limit_on && (demand > lim_duty);
  wire logic [3:0] duty_next = !enabled ? 4'h0 :
                               (limiting ? lim_duty : demand);
  wire logic tick_done = (tick_reg == TENTH_CYCLES - 22'h1);
  wire logic wrap      = tick_done && (phase_reg == DUTY_FULL - DUTY_ONE);
  wire logic pwm_on    = (phase_reg < duty_reg);
  wire logic heat_next = sensor_lost ? ctrl_reg[CTRL_FAILON_BIT] : pwm_on;
  // Limiting state as it will stand after this edge, so the alarm never lags it
  wire logic lim_next  = wrap ? (enabled && limiting) : lim_reg;

  // Alarm conditions
  logic [AL_COUNT-1:0] alarm_next;
  always_comb begin
    alarm_next = alarm_reg;
    if (temp_s < $signed({lot_reg[15], lot_reg})) alarm_next[AL_LO_TEMP] = 1'b1;
    else if (temp_s > $signed({lot_reg[15], lot_reg})) alarm_next[AL_LO_TEMP] = 1'b0;
    alarm_next[AL_HI_TEMP] = temp_s > $signed({hit_reg[15], hit_reg});
    alarm_next[AL_LO_CUR]  = heat_reg && (cur_full < loc_reg);
    alarm_next[AL_HI_CUR]  = !lim_next && heat_reg && (MEAS.current > hic_reg);
    alarm_next[AL_GF_TRIP] = MEAS.gf_cur > gft_reg;
    alarm_next[AL_GF]      = MEAS.gf_cur > gfa_reg;
    alarm_next[AL_SENS_A]  = !MEAS.sens_a_ok;
    alarm_next[AL_SENS_B]  = !MEAS.sens_b_ok;
    alarm_next[AL_SW_FAIL] = EXT.sw_fail;
    alarm_next[AL_LO_VOLT] = EXT.lo_volt;
    alarm_next[AL_HI_VOLT] = EXT.hi_volt;
    alarm_next[AL_HI_CUR_TRIP] = EXT.hi_cur_trip;
    alarm_next[AL_GF_TEST]     = EXT.gf_test_fail;
    alarm_next[AL_TT_GF]       = EXT.tt_gf;
    alarm_next[AL_TT_LO_CUR]   = EXT.tt_lo_cur;
    alarm_next[AL_TT_HI_CUR]   = EXT.tt_hi_cur;
    alarm_next[AL_TT_GF_TRIP]  = EXT.tt_gf_trip;
    alarm_next[AL_TT_SW_FAIL]  = EXT.tt_sw_fail;
  end

  // Read mux
  logic [15:0] rd_mux;
  always_comb begin
    case (ADDR)
      REG_CTRL:     rd_mux = ctrl_reg;
      REG_SETPOINT: rd_mux = setp_reg;
      REG_DEADBAND: rd_mux = db_reg;
      REG_LO_TEMP:  rd_mux = lot_reg;
      REG_HI_TEMP:  rd_mux = hit_reg;
      REG_LO_CUR:   rd_mux = loc_reg;
      REG_HI_CUR:   rd_mux = hic_reg;
      REG_PLIMIT:   rd_mux = pl_reg;
      REG_GF_LIMIT: rd_mux = gfa_reg;
      REG_GF_TRIP:  rd_mux = gft_reg;
      REG_TEMP:     rd_mux = MEAS.temp;
      REG_CURRENT:  rd_mux = MEAS.current;
      REG_GF_CUR:   rd_mux = MEAS.gf_cur;
      REG_STATUS:   rd_mux = {13'h0, lim_reg, |alarm_reg, heat_reg};
      REG_ALARM:    rd_mux = alarm_reg[15:0];
      REG_DUTY:     rd_mux = {8'h0, 2'(alarm_reg[AL_COUNT-1:16]), 2'h0, duty_reg};
      default:      rd_mux = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= CTRL_RST;
      setp_reg <= SETPOINT_RST;
      db_reg   <= DEADBAND_RST;
      lot_reg  <= 16'h0000;
      hit_reg  <= 16'h7fff;
      loc_reg  <= 16'h0000;
      hic_reg  <= 16'hffff;
      pl_reg   <= 16'h0000;
      gfa_reg  <= 16'hffff;
      gft_reg  <= 16'hffff;
    end else if (CE && WR) begin
      case (ADDR)
        REG_CTRL:     ctrl_reg <= WDATA;
        REG_SETPOINT: setp_reg <= WDATA;
        REG_DEADBAND: db_reg   <= WDATA;
        REG_LO_TEMP:  lot_reg  <= WDATA;
        REG_HI_TEMP:  hit_reg  <= WDATA;
        REG_LO_CUR:   loc_reg  <= WDATA;
        REG_HI_CUR:   hic_reg  <= WDATA;
        REG_PLIMIT:   pl_reg   <= WDATA;
        REG_GF_LIMIT: gfa_reg  <= WDATA;
        REG_GF_TRIP:  gft_reg  <= WDATA;
        default:      ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control state and outputs
  // ----------------------------------------------------------------
  // Duty is latched once per 1 s window so the average stays honest
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tick_reg  <= 22'h0;
      phase_reg <= 4'h0;
      duty_reg  <= 4'h0;
      call_reg  <= 1'b0;
      lim_reg   <= 1'b0;
      full_reg  <= 16'h0000;
    end else if (CE) begin
      tick_reg  <= tick_done ? 22'h0 : tick_reg + 22'h1;
      if (tick_done)
        phase_reg <= wrap ? 4'h0 : phase_reg + 4'h1;
      if (wrap) begin
        duty_reg <= duty_next;
        call_reg <= call_next;
        lim_reg  <= lim_next;
        // Keep the last full-duty reading for windows with the output off
        if (duty_reg != 4'h0)
          full_reg <= cur_full;
      end
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      heat_reg      <= 1'b0;
      alarm_reg     <= '0;
      rdata_reg     <= 16'h0000;
      heat_out_reg  <= 1'b0;
      alarm_any_reg <= 1'b0;
    end else if (CE) begin
      heat_reg      <= heat_next;
      alarm_reg     <= alarm_next;
      rdata_reg     <= RD ? rd_mux : 16'h0000;
      heat_out_reg  <= heat_next;
      alarm_any_reg <= |alarm_next;
    end
  end

  assign RDATA     = rdata_reg;
  assign HEAT_OUT  = heat_out_reg;
  assign ALARM_ANY = alarm_any_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  // Sensor loss overrides the modulator on the very next cycle
  AST_SENSOR_DEFAULT: assert property (
    CE && sensor_lost |=> HEAT_OUT == $past(ctrl_reg[CTRL_FAILON_BIT]))
    else $error("Output ignores sensor loss default");
  // Temperature alarms follow their levels one cycle later
  AST_HI_TEMP: assert property (
    CE && temp_s > $signed({hit_reg[15], hit_reg}) |=> alarm_reg[AL_HI_TEMP])
    else $error("High temperature alarm missing");
  AST_LO_TEMP_CLR: assert property (
    CE && temp_s > $signed({lot_reg[15], lot_reg}) |=> !alarm_reg[AL_LO_TEMP])
    else $error("Low temperature alarm did not clear");
  // Limiting and the high current alarm never show together
  AST_HI_CUR_SUPPR: assert property (
    lim_reg |-> !alarm_reg[AL_HI_CUR])
    else $error("High current alarm while limiting");
  AST_DUTY_RANGE: assert property (
    duty_reg <= DUTY_FULL)
    else $error("Duty beyond full");
  // Hysteresis of the on/off call
  AST_ONOFF_CALL: assert property (
    CE && wrap && !prop_mode && below_on |=> call_reg)
    else $error("Heater not called below turn-on point");
  AST_ONOFF_HOLD: assert property (
    CE && wrap && !below_on && !above_off |=> call_reg == $past(call_reg))
    else $error("Heater state changed inside deadband");
  // Duty never passes the limit step, and a too-low limit keeps it off
  AST_LIMIT: assert property (
    CE && wrap && enabled && limit_on |=> duty_reg <= $past(lim_duty))
    else $error("Duty exceeds limit step");
  AST_MIN_STEP_OFF: assert property (
    CE && wrap && enabled && limit_on && !min_step_fits |=> duty_reg == 4'h0)
    else $error("Output runs below the minimum step");
  // Proportional demand is zero at or above the setpoint
  AST_PROP_ZERO: assert property (
    CE && wrap && prop_mode && err <= 0 |=> duty_reg == 4'h0)
    else $error("Proportional duty above setpoint");
  // Status word carries the heater state
  AST_STATUS_RD: assert property (
    RD && CE && ADDR == REG_STATUS |=> RDATA[0] == $past(heat_reg))
    else $error("Status read wrong");
  AST_DISABLED_OFF: assert property (
    CE && wrap && !enabled |=> duty_reg == 4'h0)
    else $error("Disabled heater has duty");

  COV_LIMITING: cover property (lim_reg && heat_reg);
  COV_FAIL_ON:  cover property (sensor_lost && HEAT_OUT);
  COV_PROP:     cover property (prop_mode && duty_reg > 4'h0 && duty_reg < DUTY_FULL);
  COV_MIN_STEP: cover property (limit_on && !min_step_fits && duty_reg == 4'h0);
  COV_HOLD_DB:  cover property (wrap && !below_on && !above_off && call_reg);

endmodule : htc_heater

// file: pkg/htc_pkg.sv
// Package for the heat trace control and alarm block.
// Assumes one 40 MHz clock and a simple strobe register port.
package htc_pkg;

  // ----------------------------------------------------------------
  // Register map (word index on the register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL      = 4'h0; // Mode, enable, fail default
  localparam logic [3:0] REG_SETPOINT  = 4'h1; // Setpoint, 0.1 C units
  localparam logic [3:0] REG_DEADBAND  = 4'h2; // Deadband, 0.1 C units
  localparam logic [3:0] REG_LO_TEMP   = 4'h3; // Low temperature alarm level
  localparam logic [3:0] REG_HI_TEMP   = 4'h4; // High temperature alarm level
  localparam logic [3:0] REG_LO_CUR    = 4'h5; // Low current alarm, 10 mA units
  localparam logic [3:0] REG_HI_CUR    = 4'h6; // High current alarm, 10 mA units
  localparam logic [3:0] REG_PLIMIT    = 4'h7; // Power limit, 10 mA units, 0 = off
  localparam logic [3:0] REG_GF_LIMIT  = 4'h8; // Ground fault alarm level, 1 mA units
  localparam logic [3:0] REG_GF_TRIP   = 4'h9; // Ground fault trip level, 1 mA units
  localparam logic [3:0] REG_TEMP      = 4'ha; // Measured temperature
  localparam logic [3:0] REG_CURRENT   = 4'hb; // Measured current
  localparam logic [3:0] REG_GF_CUR    = 4'hc; // Measured ground fault current
  localparam logic [3:0] REG_STATUS    = 4'hd; // Heater status word
  localparam logic [3:0] REG_ALARM     = 4'he; // Heater alarm word
  localparam logic [3:0] REG_DUTY      = 4'hf; // Duty step in tenths

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_PROP_BIT   = 0; // 1 = proportional
  localparam int CTRL_ENA_BIT    = 1; // Heater enable
  localparam int CTRL_FAILON_BIT = 2; // Output state on sensor loss
  localparam logic [15:0] CTRL_RST     = 16'h0002; // On/off, enabled, fail off
  localparam logic [15:0] SETPOINT_RST = 16'h0064;
  localparam logic [15:0] DEADBAND_RST = 16'h0014;
  localparam logic [3:0]  DUTY_FULL    = 4'ha; // Ten tenths
  localparam logic [3:0]  DUTY_ONE     = 4'h1;
  localparam int PROP_BAND_SHIFT = 2;  // Internal gain: band = 4 x deadband
  localparam logic [21:0] PWM_TENTH = 22'h3d0900; // 0.1 s at 40 MHz

  // Alarm word bit positions
  typedef enum int {
    AL_LO_TEMP, AL_HI_TEMP, AL_LO_CUR, AL_HI_CUR, AL_GF_TRIP, AL_GF,
    AL_SENS_A, AL_SENS_B, AL_SW_FAIL, AL_LO_VOLT, AL_HI_VOLT, AL_HI_CUR_TRIP,
    AL_GF_TEST, AL_TT_GF, AL_TT_LO_CUR, AL_TT_HI_CUR, AL_TT_GF_TRIP, AL_TT_SW_FAIL,
    AL_COUNT
  } htc_alarm_e;

  // Measurements entering the block
  typedef struct packed {
    logic [15:0] temp;      // Signed, 0.1 C
    logic [15:0] current;   // 10 mA
    logic [15:0] gf_cur;    // 1 mA
    logic        sens_a_ok;
    logic        sens_b_ok;
  } htc_meas_s;

  // Flags raised elsewhere in the controller
  typedef struct packed {
    logic lo_volt, hi_volt, sw_fail, hi_cur_trip, gf_test_fail;
    logic tt_gf, tt_lo_cur, tt_hi_cur, tt_gf_trip, tt_sw_fail;
  } htc_ext_s;

endpackage : htc_pkg

// file: sim/htc_gw_model.sv
// Polling gateway model standing on the register port of one heater block.
// Assumes one clock; the bench calls its tasks to write and poll registers.
`timescale 1ns/1ps
module htc_gw_model
  import htc_pkg::*;
#(
  parameter logic [7:0] MODULE_NUM = 8'h05 // Own number on the shared link, arbitrary
) (
  input  wire logic  clk,
  output logic [3:0]  addr,
  output logic [15:0] wdata,
  output logic        wr,
  output logic        rd,
  output logic        rd_done
);
  // ----------------------------------------------------------------
  // Bus cycles
  // ----------------------------------------------------------------
  initial begin
    addr  = 4'h0;
    wdata = 16'h0000;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // Marks the cycle in which read data stand
  always @(posedge clk) begin
    rd_done <= rd;
  end

  // One-cycle write; idle lines then show inverted values, never the old ones
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
  endtask : wr_reg

  // One-cycle poll of a register
  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
  endtask : rd_reg
endmodule : htc_gw_model

// file: sim/tb.sv
// Self-checking bench for the heater control and alarm block.
// Assumes the gateway model drives the register port; measurements come from here.
`timescale 1ns/1ps
module tb;
  import htc_pkg::*;
  localparam logic [21:0] TENTH = 22'h000004;
  localparam int          WIN   = 40;
  localparam int          NOM   = 200;
  typedef struct packed {logic [15:0] val; logic [15:0] msk;} htc_note_s;
  logic CLK, RST, CE, wr, rd, rd_done, heat, alarm_any, sa_v, sb_v, sa_e, sb_e;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata, temp_v, cur_v, gf_v;
  logic [31:0] seed;
  logic [39:0] hist = '0;
  htc_meas_s   meas;
  htc_ext_s    ext_v, x;
  htc_note_s   notes[$];
  htc_note_s   nt;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          tv[7] = '{70, 100, 130, 100, 40, 60, 160};
  logic [2:0]  ev[7] = '{3'b001, 3'b001, 3'b000, 3'b000, 3'b011, 3'b001, 3'b100};

  // ----------------------------------------------------------------
  // Clock, measurements and instances
  // ----------------------------------------------------------------
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Heater current averaged over one control window
  always @(posedge CLK) begin
    hist  <= {hist[38:0], heat};
    cur_v <= 16'(NOM * $countones(hist) / WIN);
  end
  assign meas = '{temp: temp_v, current: cur_v, gf_cur: gf_v, sens_a_ok: sa_v, sens_b_ok: sb_v};

  htc_gw_model i_gw (.clk(CLK), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rd_done(rd_done));
  htc_heater #(.TENTH_CYCLES(TENTH)) i_dut (.CLK(CLK), .RST(RST), .CE(CE), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .MEAS(meas), .EXT(ext_v), .RDATA(rdata),
    .HEAT_OUT(heat), .ALARM_ANY(alarm_any));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  task automatic chk(input logic [15:0] seen, input logic [15:0] e, input logic [15:0] m);
    cmp_count++;
    if ((seen & m) !== (e & m)) begin
      miscompares++;
      $display("BAD %0t saw %h expected %h", $time, seen, e);
    end
  endtask : chk

  // Notes the expectation, then polls
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
    notes.push_back('{val: e, msk: m});
    i_gw.rd_reg(a);
  endtask : rd_chk

  task automatic print_verdict();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Read data monitor: takes the oldest note when data stand
  always @(negedge CLK) begin
    if (rd_done === 1'b1) begin
      if (notes.size() == 0) begin
        miscompares++;
        $display("BAD %0t read data without a note", $time);
      end else begin
        nt = notes.pop_front();
        chk(rdata, nt.val, nt.msk);
      end
    end
  end

  // Bound on the whole run
  initial begin
    repeat (20000) @(posedge CLK);
    miscompares++;
    $display("BAD %0t run did not finish", $time);
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    temp_v = 16'd70;
    gf_v = 16'h0007;
    sa_v = 1'b1;
    sb_v = 1'b1;
    ext_v = '0;
    seed = 32'h4b4b;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    // Reset values, then thresholds and a refused write
    rd_chk(REG_CTRL, CTRL_RST, 16'hffff);
    rd_chk(REG_SETPOINT, SETPOINT_RST, 16'hffff);
    rd_chk(REG_DEADBAND, DEADBAND_RST, 16'hffff);
    i_gw.wr_reg(REG_LO_TEMP, 16'd50);
    i_gw.wr_reg(REG_HI_TEMP, 16'd150);
    i_gw.wr_reg(REG_LO_CUR, 16'h0000);
    i_gw.wr_reg(REG_HI_CUR, 16'hffff);
    i_gw.wr_reg(REG_GF_LIMIT, 16'hffff);
    i_gw.wr_reg(REG_GF_TRIP, 16'hffff);
    i_gw.wr_reg(REG_TEMP, 16'h1234);
    rd_chk(REG_TEMP, 16'd70, 16'hffff);
    rd_chk(REG_GF_CUR, 16'h0007, 16'hffff);
    // Hysteresis and temperature alarms over a table of temperatures
    for (int i = 0; i < 7; i++) begin
      temp_v <= 16'(tv[i]);
      repeat (3 * WIN) @(posedge CLK);
      @(negedge CLK);
      chk({15'h0, alarm_any}, {15'h0, |ev[i][2:1]}, 16'h0001);
      rd_chk(REG_STATUS, {14'h0, |ev[i][2:1], ev[i][0]}, 16'h0003);
      rd_chk(REG_ALARM, {14'h0, ev[i][2:1]}, 16'h0003);
    end
    // Random external and sensor flags
    temp_v <= 16'd70;
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      x = htc_ext_s'(seed[9:0]);
      sa_e = seed[10];
      sb_e = seed[11] | ~seed[10];
      ext_v <= x;
      sa_v <= sa_e;
      sb_v <= sb_e;
      repeat (3) @(posedge CLK);
      rd_chk(REG_ALARM, {x.tt_hi_cur, x.tt_lo_cur, x.tt_gf, x.gf_test_fail, x.hi_cur_trip,
        x.hi_volt, x.lo_volt, x.sw_fail, ~sb_e, ~sa_e, 6'h00}, 16'hffc0);
      rd_chk(REG_DUTY, {8'h00, x.tt_sw_fail, x.tt_gf_trip, 6'h00}, 16'h00c0);
    end
    ext_v <= '0;
    sa_v <= 1'b1;
    sb_v <= 1'b1;
    // Proportional mode: 40 below setpoint over a band of 80 gives half duty
    i_gw.wr_reg(REG_CTRL, 16'h0003);
    temp_v <= 16'd60;
    repeat (4 * WIN) @(posedge CLK);
    rd_chk(REG_DUTY, 16'h0005, 16'h000f);
    i_gw.wr_reg(REG_CTRL, CTRL_RST);
    // Power limit 1.5 A on a 2 A heater settles at seven tenths
    temp_v <= 16'd70;
    i_gw.wr_reg(REG_LO_CUR, 16'd180);
    i_gw.wr_reg(REG_HI_CUR, 16'd100);
    i_gw.wr_reg(REG_PLIMIT, 16'd150);
    repeat (15 * WIN) @(posedge CLK);
    rd_chk(REG_DUTY, 16'h0007, 16'h000f);
    rd_chk(REG_ALARM, 16'h0000, 16'h000c);
    rd_chk(REG_STATUS, 16'h0005, 16'h0005);
    // A limit below one tenth keeps the output off
    i_gw.wr_reg(REG_PLIMIT, 16'd10);
    repeat (6 * WIN) @(posedge CLK);
    rd_chk(REG_DUTY, 16'h0000, 16'h000f);
    @(negedge CLK);
    chk({15'h0, heat}, 16'h0000, 16'h0001);
    i_gw.wr_reg(REG_PLIMIT, 16'h0000);
    // Loss of both sensors forces the configured default
    temp_v <= 16'd130;
    sa_v <= 1'b0;
    sb_v <= 1'b0;
    i_gw.wr_reg(REG_CTRL, 16'h0006);
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    chk({15'h0, heat}, 16'h0001, 16'h0001);
    rd_chk(REG_STATUS, 16'h0001, 16'h0001);
    i_gw.wr_reg(REG_CTRL, CTRL_RST);
    repeat (3) @(posedge CLK);
    @(negedge CLK);
    chk({15'h0, heat}, 16'h0000, 16'h0001);
    repeat (3) @(posedge CLK);
    if (notes.size() != 0) begin
      miscompares++;
      $display("BAD %0t reads left unanswered", $time);
    end
    print_verdict();
  end
endmodule : tb
